/* File: common/cbr_pkg.sv */
// Contract
// - four kilobit synchronous storage per instance
// - shapes 256x16, 512x8, 1024x4, 2048x2
// - write address 8 to 11 bits
// - independent read address, same width
// - bit mask only in 16-bit shape
// - mask zero writes, mask one keeps
// - inputs registered at array on edge
// - write needs enable and clock enable
// - read needs enable and clock enable
// - write edge rising, falling by option
// - read edge rising, falling by option
// - optional initial contents at configuration
// - single, pseudo dual port, fifo use
package cbr_pkg;

    // storage geometry
    localparam int unsigned MEM_BITS   = 4096;   // total bits per instance
    localparam int unsigned MAX_DW     = 16;     // widest data port
    localparam int unsigned MAX_AW     = 11;     // widest address port
    localparam int unsigned IDX_W      = 8;      // physical word index width
    localparam int unsigned WORDS      = 256;    // physical 16-bit words
    localparam int unsigned SHIFT_W    = 4;      // bit offset within a word

    // edge choice for a port clock
    localparam logic        EDGE_RISE  = 1'b0;   // default sensitivity
    localparam logic        EDGE_FALL  = 1'b1;   // falling-edge option

    // reset values
    localparam logic [15:0] DATA_RST   = 16'h0000;
    localparam logic [7:0]  IDX_RST    = 8'h00;
    localparam logic [3:0]  SHIFT_RST  = 4'h0;

    // write port sample
    typedef struct packed {
        logic        en;       // write enable
        logic        clken;    // write clock enable
        logic [10:0] loc;      // location, zero padded
        logic [15:0] data;     // data, zero padded
        logic [15:0] mask;     // per-bit mask, one keeps
    } cbr_wr_s;

    // read port sample
    typedef struct packed {
        logic        en;       // read enable
        logic        clken;    // read clock enable
        logic [10:0] loc;      // location, zero padded
    } cbr_rd_s;

    // address width for a data width
    function automatic int unsigned cbr_addr_w(input int unsigned dw);
        int unsigned aw;
        aw = 8;
        case (dw)
            16:      aw = 8;
            8:       aw = 9;
            4:       aw = 10;
            2:       aw = 11;
            default: aw = 8;
        endcase
        return aw;
    endfunction

endpackage

/* File: src/cbr_edge_sync.sv */
`timescale 1ns/10ps
// brings one port clock and its bus into mclk
module cbr_edge_sync #(
    parameter int unsigned W    = 13,            // bus width
    parameter logic        FALL = 1'b0           // one selects falling edge
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         port_clk,
    input  wire logic [W-1:0] port_bus,
    output logic              edge_seen,
    output logic [W-1:0]      bus_sync
);

    logic         clk_meta_r;   // first stage, read by second only
    logic         clk_sync_r;   // second stage
    logic         clk_prev_r;   // delayed copy for edge detect
    logic [W-1:0] bus_meta_r;   // first stage of bus
    logic [W-1:0] bus_sync_r;   // second stage of bus

    // two-stage synchroniser for the port clock
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            clk_meta_r <= 1'b0;
            clk_sync_r <= 1'b0;
            clk_prev_r <= 1'b0;
        end else begin
            clk_meta_r <= port_clk;
            clk_sync_r <= clk_meta_r;
            clk_prev_r <= clk_sync_r;
        end
    end

    // bus follows the same two stages so it lines up with the edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bus_meta_r <= '0;
            bus_sync_r <= '0;
        end else begin
            bus_meta_r <= port_bus;
            bus_sync_r <= bus_meta_r;
        end
    end

    // selected edge of the synchronised clock
    always_comb begin
        if (FALL == cbr_pkg::EDGE_FALL) begin
            edge_seen = clk_prev_r & ~clk_sync_r;
        end else begin
            edge_seen = ~clk_prev_r & clk_sync_r;
        end
    end

    assign bus_sync = bus_sync_r;

endmodule

/* File: src/cbr_ram.sv */
`timescale 1ns/10ps
// four kilobit block ram with separate write and read ports
module cbr_ram #(
    parameter int unsigned DATA_W     = 16,                          // 16, 8, 4 or 2
    parameter int unsigned ADDR_W     = cbr_pkg::cbr_addr_w(DATA_W), // follows data width
    parameter logic        WRITE_FALL = cbr_pkg::EDGE_RISE,          // write edge option
    parameter logic        READ_FALL  = cbr_pkg::EDGE_RISE,          // read edge option
    parameter logic [4095:0] INIT     = '0                           // preload, word 0 lowest
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              write_clock,
    input  wire logic              write_enable,
    input  wire logic              write_clock_enable,
    input  wire logic [ADDR_W-1:0] write_location,
    input  wire logic [DATA_W-1:0] write_data,
    input  wire logic [15:0]       write_mask,
    input  wire logic              read_clock,
    input  wire logic              read_enable,
    input  wire logic              read_clock_enable,
    input  wire logic [ADDR_W-1:0] read_location,
    output logic      [DATA_W-1:0] read_data,
    output logic                   read_valid,
    output logic                   write_done,
    output logic                   collision
);

    // address bits that pick a lane inside a 16-bit word
    localparam int unsigned SUB_W = ADDR_W - cbr_pkg::IDX_W;

    // write and read samples as seen in mclk
    cbr_pkg::cbr_wr_s wr_pin;      // padded pin values
    cbr_pkg::cbr_wr_s wr_smp;      // synchronised values
    cbr_pkg::cbr_rd_s rd_pin;      // padded pin values
    cbr_pkg::cbr_rd_s rd_smp;      // synchronised values
    logic             wr_edge;     // active write clock edge
    logic             rd_edge;     // active read clock edge
    logic             wr_go;       // qualified write
    logic             rd_go;       // qualified read

    // storage array
    logic [15:0]      mem_r [cbr_pkg::WORDS];

    // input registers at the array
    logic             wr_pend_r;   // captured write waiting
    logic [7:0]       wr_idx_r;    // captured word index
    logic [15:0]      wr_bits_r;   // bits to change
    logic [15:0]      wr_val_r;    // data aligned to lane
    logic             rd_pend_r;   // captured read waiting
    logic [7:0]       rd_idx_r;    // captured word index
    logic [3:0]       rd_shift_r;  // captured lane offset

    // output flops and next read data
    logic [DATA_W-1:0] read_data_r;
    logic [DATA_W-1:0] read_data_nxt;
    logic              read_valid_r;
    logic              write_done_r;
    logic              collision_r;

    // physical word from a padded location
    function automatic logic [7:0] word_index(input logic [10:0] loc);
        logic [10:0] tmp;
        tmp = loc >> SUB_W;
        return tmp[7:0];
    endfunction

    // bit offset of the lane inside the word
    function automatic logic [3:0] lane_shift(input logic [10:0] loc);
        logic [10:0] low;
        logic [10:0] prod;
        low  = loc & 11'((32'h1 << SUB_W) - 32'h1);
        prod = 11'(low * 11'(DATA_W));
        return prod[3:0];
    endfunction

    // bits a write may change in its word
    function automatic logic [15:0] lane_bits(input logic [10:0] loc, input logic [15:0] mask);
        logic [15:0] lane;
        lane = 16'((32'h1 << DATA_W) - 32'h1);
        if (DATA_W == cbr_pkg::MAX_DW) begin
            return ~mask;
        end
        return lane << lane_shift(loc);
    endfunction

    // pad port values to the carrier widths
    always_comb begin
        wr_pin.en    = write_enable;
        wr_pin.clken = write_clock_enable;
        wr_pin.loc   = 11'(write_location);
        wr_pin.data  = 16'(write_data);
        wr_pin.mask  = write_mask;
        rd_pin.en    = read_enable;
        rd_pin.clken = read_clock_enable;
        rd_pin.loc   = 11'(read_location);
    end

    // write port on its own clock and edge choice
    cbr_edge_sync #(
        .W    ($bits(cbr_pkg::cbr_wr_s)),
        .FALL (WRITE_FALL)
    ) u_wr_sync (
        .mclk      (mclk),
        .rst       (rst),
        .port_clk  (write_clock),
        .port_bus  (wr_pin),
        .edge_seen (wr_edge),
        .bus_sync  (wr_smp)
    );

    // read port on its own clock and edge choice
    cbr_edge_sync #(
        .W    ($bits(cbr_pkg::cbr_rd_s)),
        .FALL (READ_FALL)
    ) u_rd_sync (
        .mclk      (mclk),
        .rst       (rst),
        .port_clk  (read_clock),
        .port_bus  (rd_pin),
        .edge_seen (rd_edge),
        .bus_sync  (rd_smp)
    );

    // qualification of each port
    assign wr_go = wr_edge & wr_smp.en & wr_smp.clken;
    assign rd_go = rd_edge & rd_smp.en & rd_smp.clken;

    // write input register, loaded on a qualified edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= cbr_pkg::IDX_RST;
            wr_bits_r <= cbr_pkg::DATA_RST;
            wr_val_r  <= cbr_pkg::DATA_RST;
        end else begin
            wr_pend_r <= wr_go;
            if (wr_go) begin
                // address, data and mask held at the array input
                wr_idx_r  <= word_index(wr_smp.loc);
                wr_bits_r <= lane_bits(wr_smp.loc, wr_smp.mask);
                wr_val_r  <= wr_smp.data << lane_shift(wr_smp.loc);
            end
        end
    end

    // read input register, loaded on a qualified edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_pend_r  <= 1'b0;
            rd_idx_r   <= cbr_pkg::IDX_RST;
            rd_shift_r <= cbr_pkg::SHIFT_RST;
        end else begin
            rd_pend_r <= rd_go;
            if (rd_go) begin
                // read location held independently of write side
                rd_idx_r   <= word_index(rd_smp.loc);
                rd_shift_r <= lane_shift(rd_smp.loc);
            end
        end
    end

    // storage: preload at reset, masked update from the input register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < cbr_pkg::WORDS; i++) begin
                // initial contents present before first access
                mem_r[i] <= INIT[i*cbr_pkg::MAX_DW +: cbr_pkg::MAX_DW];
            end
        end else if (wr_pend_r) begin
            // only enabled bits change, the rest keep their value
            mem_r[wr_idx_r] <= (mem_r[wr_idx_r] & ~wr_bits_r) | (wr_val_r & wr_bits_r);
        end
    end

    // lane extract for the read output
    always_comb begin
        logic [15:0] word;
        word          = mem_r[rd_idx_r] >> rd_shift_r;
        read_data_nxt = word[DATA_W-1:0];
    end

    // read output: new word after a qualified read, else held
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            read_data_r <= '0;
        end else if (rd_pend_r) begin
            // array read sees data before a same-cycle write
            read_data_r <= read_data_nxt;
        end
    end

    // one-cycle strobes for completed accesses
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            read_valid_r <= 1'b0;
            write_done_r <= 1'b0;
        end else begin
            read_valid_r <= rd_pend_r;
            write_done_r <= wr_pend_r;
        end
    end

    // read and write of one word in one cycle: old data returned
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            collision_r <= 1'b0;
        end else begin
            collision_r <= rd_pend_r & wr_pend_r & (rd_idx_r == wr_idx_r);
        end
    end

    // outputs straight from flops
    assign read_data  = read_data_r;
    assign read_valid = read_valid_r;
    assign write_done = write_done_r;
    assign collision  = collision_r;

endmodule

/* File: tb/cbr_ram_asserts.sv */
`timescale 1ns/10ps
// port timing checks for one ram instance, all in the mclk domain
module cbr_ram_asserts #(
    parameter int unsigned DATA_W     = 16,    // read data width
    parameter logic        WRITE_FALL = 1'b0,  // write edge option
    parameter logic        READ_FALL  = 1'b0   // read edge option
) (
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              write_clock,
    input wire logic              write_enable,
    input wire logic              write_clock_enable,
    input wire logic              read_clock,
    input wire logic              read_enable,
    input wire logic              read_clock_enable,
    input wire logic [DATA_W-1:0] read_data,
    input wire logic              read_valid,
    input wire logic              write_done,
    input wire logic              collision
);
    logic wclk_r;  // last sampled write clock
    logic rclk_r;  // last sampled read clock
    logic wedge;   // active write edge seen
    logic redge;   // active read edge seen

    // previous port clock levels, idle after reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wclk_r <= WRITE_FALL;
            rclk_r <= READ_FALL;
        end else begin
            wclk_r <= write_clock;
            rclk_r <= read_clock;
        end
    end
    assign wedge = (write_clock != wclk_r) && (write_clock == !WRITE_FALL);
    assign redge = (read_clock != rclk_r) && (read_clock == !READ_FALL);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_write_taken: assert property (wedge && write_enable && write_clock_enable |-> ##[2:5] write_done)
        else $error("qualified write gave no done pulse");
    chk_write_refused: assert property (wedge && !(write_enable && write_clock_enable) |-> ##1 !write_done [*6])
        else $error("refused write gave a done pulse");
    chk_done_cause: assert property (write_done |-> $past(write_enable, 3) && $past(write_clock_enable, 3))
        else $error("done pulse without enables");
    chk_done_single: assert property (write_done |=> !write_done)
        else $error("done pulse longer than one cycle");
    chk_read_taken: assert property (redge && read_enable && read_clock_enable |-> ##[2:5] read_valid)
        else $error("qualified read gave no valid");
    chk_read_refused: assert property (redge && !(read_enable && read_clock_enable) |-> ##1 !read_valid [*6])
        else $error("refused read gave valid");
    chk_valid_cause: assert property (read_valid |-> $past(read_enable, 3) && $past(read_clock_enable, 3))
        else $error("valid without read enables");
    chk_data_holds: assert property ($changed(read_data) |-> read_valid)
        else $error("read data moved without a read");
    chk_reset_quiet: assert property ($fell(rst) |-> !read_valid && !write_done && read_data == '0)
        else $error("outputs not cleared by reset");
    chk_collide_pair: assert property (collision |-> read_valid && write_done)
        else $error("collision flagged without both accesses");
endmodule

bind cbr_ram cbr_ram_asserts #(.DATA_W(DATA_W), .WRITE_FALL(WRITE_FALL), .READ_FALL(READ_FALL)) u_cbr_ram_asserts (
    .mclk(mclk), .rst(rst), .write_clock(write_clock), .write_enable(write_enable),
    .write_clock_enable(write_clock_enable), .read_clock(read_clock), .read_enable(read_enable),
    .read_clock_enable(read_clock_enable), .read_data(read_data), .read_valid(read_valid),
    .write_done(write_done), .collision(collision));

/* File: tb/cbr_user_model.sv */
`timescale 1ns/10ps
// user logic on both ports; port clocks rest at the inactive level
module cbr_user_model #(
    parameter logic FALL = 1'b0  // one makes the active edge falling
) (
    input  wire logic        mclk,
    output logic             wclk,
    output cbr_pkg::cbr_wr_s wr,
    output logic             rclk,
    output cbr_pkg::cbr_rd_s rd
);
    // idle levels at time zero
    initial begin
        wclk = FALL;
        rclk = FALL;
        wr   = '0;
        rd   = '0;
    end

    // one write: set up a cycle ahead, edge, hold four, release inverted
    task automatic wr_op(input logic [10:0] a, input logic [15:0] d, input logic [15:0] m, input logic e, input logic c);
        @(posedge mclk);
        wr <= '{en: e, clken: c, loc: a, data: d, mask: m};
        @(posedge mclk);
        wclk <= ~FALL;
        repeat (4) @(posedge mclk);
        wclk <= FALL;
        wr <= '{en: 1'b0, clken: 1'b0, loc: ~a, data: ~d, mask: ~m};
        repeat (3) @(posedge mclk);
    endtask

    // one read, same spacing as a write
    task automatic rd_op(input logic [10:0] a, input logic e, input logic c);
        @(posedge mclk);
        rd <= '{en: e, clken: c, loc: a};
        @(posedge mclk);
        rclk <= ~FALL;
        repeat (4) @(posedge mclk);
        rclk <= FALL;
        rd <= '{en: 1'b0, clken: 1'b0, loc: ~a};
        repeat (3) @(posedge mclk);
    endtask
endmodule

/* File: tb/cbr_ram_tb.sv */
`timescale 1ns/10ps
// wide rising-edge ram with preload, narrow falling-edge ram beside it
module cbr_ram_tb;
    localparam logic [4095:0] PRE = {4064'h0, 32'hbeef_1234};  // words 1 and 0 preloaded
    logic             mclk;
    logic             rst;
    logic             wc_a, rc_a, wc_b, rc_b;  // port clocks
    cbr_pkg::cbr_wr_s wr_a, wr_b;              // write port bundles
    cbr_pkg::cbr_rd_s rd_a, rd_b;              // read port bundles
    logic [15:0]      dat_a;
    logic [3:0]       dat_b;
    logic [1:0]       dat_c;                   // two-bit ram, mixed edges
    logic             val_a, val_b, val_c, seen, hit, col_a;
    int               n_errors, cmp_count;

    cbr_user_model u_cbr_user_model (.mclk(mclk), .wclk(wc_a), .wr(wr_a), .rclk(rc_a), .rd(rd_a));
    cbr_user_model #(.FALL(1'b1)) u_cbr_user_model_n (.mclk(mclk), .wclk(wc_b), .wr(wr_b), .rclk(rc_b), .rd(rd_b));
    cbr_ram #(.DATA_W(16), .INIT(PRE)) u_cbr_ram (
        .mclk(mclk), .rst(rst), .write_clock(wc_a), .write_enable(wr_a.en), .write_clock_enable(wr_a.clken),
        .write_location(wr_a.loc[7:0]), .write_data(wr_a.data), .write_mask(wr_a.mask), .read_clock(rc_a),
        .read_enable(rd_a.en), .read_clock_enable(rd_a.clken), .read_location(rd_a.loc[7:0]),
        .read_data(dat_a), .read_valid(val_a), .write_done(), .collision(col_a));
    cbr_ram #(.DATA_W(4), .WRITE_FALL(1'b1), .READ_FALL(1'b1)) u_cbr_ram_n (
        .mclk(mclk), .rst(rst), .write_clock(wc_b), .write_enable(wr_b.en), .write_clock_enable(wr_b.clken),
        .write_location(wr_b.loc[9:0]), .write_data(wr_b.data[3:0]), .write_mask(wr_b.mask), .read_clock(rc_b),
        .read_enable(rd_b.en), .read_clock_enable(rd_b.clken), .read_location(rd_b.loc[9:0]),
        .read_data(dat_b), .read_valid(val_b), .write_done(), .collision());
    // two-bit shape: written by the rising-edge model, read by the falling-edge one
    cbr_ram #(.DATA_W(2), .READ_FALL(1'b1)) u_cbr_ram_c (
        .mclk(mclk), .rst(rst), .write_clock(wc_a), .write_enable(wr_a.en), .write_clock_enable(wr_a.clken),
        .write_location(wr_a.loc), .write_data(wr_a.data[1:0]), .write_mask(wr_a.mask), .read_clock(rc_b),
        .read_enable(rd_b.en), .read_clock_enable(rd_b.clken), .read_location(rd_b.loc),
        .read_data(dat_c), .read_valid(val_c), .write_done(), .collision());

    // 125 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // note any valid pulse
    always @(posedge mclk) begin
        if (val_a === 1'b1 || val_b === 1'b1 || val_c === 1'b1) seen = 1'b1;
        if (col_a === 1'b1) hit = 1'b1;
    end

    task automatic check(input logic [15:0] act, input logic [15:0] exp, input string what);
        cmp_count++;
        if (act !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, act, exp);
        end
    endtask
    // read one location, check pulse and held data
    // b: 0 wide ram, 1 four-bit ram, 2 two-bit ram (both read by the falling-edge model)
    task automatic rchk(input logic [1:0] b, input logic [10:0] a, input logic [15:0] exp, input logic e, input logic c);
        seen = 1'b0;
        if (b != 2'h0) u_cbr_user_model_n.rd_op(a, e, c);
        else u_cbr_user_model.rd_op(a, e, c);
        check({15'h0, seen}, {15'h0, e & c}, "read valid");
        check(b == 2'h2 ? {14'h0, dat_c} : (b == 2'h1 ? {12'h0, dat_b} : dat_a), exp, "read data");
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic t_preload();
        rchk(0, 11'h000, 16'h1234, 1, 1);
        rchk(0, 11'h001, 16'hbeef, 1, 1);
        $display("preload test ended");
    endtask
    task automatic t_mask();
        u_cbr_user_model.wr_op(11'h002, 16'hffff, 16'h00ff, 1, 1);
        rchk(0, 11'h002, 16'hff00, 1, 1);
        u_cbr_user_model.wr_op(11'h002, 16'h1234, 16'h0ff0, 1, 1);
        rchk(0, 11'h002, 16'h1f04, 1, 1);
        $display("mask test ended");
    endtask
    task automatic t_gate();
        for (int i = 0; i < 3; i++) begin
            u_cbr_user_model.wr_op(11'h003, 16'haaaa, 16'h0000, i[0], i[1]);
        end
        rchk(0, 11'h003, 16'h0000, 1, 1);
        for (int i = 0; i < 3; i++) begin
            rchk(0, 11'h001, 16'h0000, i[0], i[1]);
        end
        $display("enable test ended");
    endtask
    task automatic t_bounds();
        u_cbr_user_model.wr_op(11'h0ff, 16'h5a5a, 16'h0000, 1, 1);
        u_cbr_user_model.wr_op(11'h0fe, 16'ha5a5, 16'h0000, 1, 1);
        rchk(0, 11'h0ff, 16'h5a5a, 1, 1);
        rchk(0, 11'h0fe, 16'ha5a5, 1, 1);
        $display("boundary test ended");
    endtask
    task automatic t_narrow();
        u_cbr_user_model_n.wr_op(11'h005, 16'h0009, 16'hffff, 1, 1);
        u_cbr_user_model_n.wr_op(11'h004, 16'h0006, 16'hffff, 1, 1);
        u_cbr_user_model_n.wr_op(11'h3ff, 16'h000c, 16'hffff, 1, 1);
        rchk(1, 11'h005, 16'h0009, 1, 1);
        rchk(1, 11'h004, 16'h0006, 1, 1);
        rchk(1, 11'h3ff, 16'h000c, 1, 1);
        rchk(1, 11'h006, 16'h0000, 1, 1);
        $display("narrow test ended");
    endtask
    task automatic t_collide();
        u_cbr_user_model.wr_op(11'h010, 16'h1111, 16'h0000, 1, 1);
        hit = 1'b0;
        fork
            u_cbr_user_model.wr_op(11'h010, 16'h7777, 16'h0000, 1, 1);
            rchk(0, 11'h010, 16'h1111, 1, 1);
        join
        check({15'h0, hit}, 16'h0001, "collision flag");
        rchk(0, 11'h010, 16'h7777, 1, 1);
        $display("collision test ended");
    endtask
    task automatic t_two_bit();
        rchk(2, 11'h0ff, 16'h0002, 1, 1);
        rchk(2, 11'h0fe, 16'h0001, 1, 1);
        rchk(2, 11'h010, 16'h0003, 1, 1);
        rchk(2, 11'h002, 16'h0000, 1, 1);
        $display("two-bit test ended");
    endtask

    // watchdog well beyond the expected few hundred cycles
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        conclude();
    end
    // main sequence
    initial begin
        rst = 1'b1;
        n_errors = 0;
        cmp_count = 0;
        seen = 1'b0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        t_preload();
        t_mask();
        t_gate();
        t_bounds();
        t_narrow();
        t_collide();
        t_two_bit();
        conclude();
    end
endmodule
